// ==== rpm_far_side.sv ====
`timescale 1ns/1ps
`default_nettype none
module rpm_far_side
(
  // clock and bench commands
  input  wire logic       sys_clk,
  input  wire logic       extReq,
  input  wire logic       droopReq,
  input  wire logic       lowReq,
  input  wire logic [1:0] deepReq,
  // pin, monitors, cpus, oscillators
  output logic            extResetN = 1'b1,
  output logic            supplyDroopDetect = 1'b0,
  output logic            supplyOk = 1'b1,
  output logic [1:0]      cpuDeepSleep = 2'h0,
  output logic            lowSpeedOscTick = 1'b0,
  output logic            watchXtalTick = 1'b0
);
  logic [3:0] cnt_r = 4'h0;

  always @(posedge sys_clk)
  begin
    cnt_r <= cnt_r + 4'h1;
    extResetN <= !extReq;
    supplyDroopDetect <= droopReq;
    supplyOk <= !lowReq;
    cpuDeepSleep <= deepReq;
    lowSpeedOscTick <= (cnt_r[1:0] == 2'h0);
    watchXtalTick <= (cnt_r[2:0] == 3'h3);
  end
endmodule
`default_nettype wire

// ==== rpm_pkg.sv ====
`default_nettype none
package rpm_pkg;
  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int RST_HOLD_NS   = 300;
  localparam int RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ------------------------------------------------------------
  // watchdog shape
  // ------------------------------------------------------------
  localparam int WD_W     = 16;
  localparam int MC_W     = 16;
  localparam int MC_LW    = 32;
  localparam int MC_NUM   = 2;
  localparam int MC_CTRS  = 3;
  localparam int MC_TOTAL = MC_NUM * MC_CTRS;
  localparam int MC_LONG  = 2;
  // ------------------------------------------------------------
  // reset cause bits
  // ------------------------------------------------------------
  localparam int CAUSE_W  = 7;
  localparam int CB_POR   = 0;
  localparam int CB_DROOP = 1;
  localparam int CB_EXT   = 2;
  localparam int CB_WDOG  = 3;
  localparam int CB_SOFT  = 4;
  localparam int CB_FAULT = 5;
  localparam int CB_HIB   = 6;
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 7'h01;
  // ------------------------------------------------------------
  // power and clock defaults
  // ------------------------------------------------------------
  localparam logic [10:0] VCORE_NORMAL_MV  = 11'h44c;
  localparam logic [10:0] VCORE_REDUCED_MV = 11'h384;
  localparam logic [7:0]  ROOT_NORMAL_MHZ  = 8'h32;
  localparam logic [7:0]  ROOT_REDUCED_MHZ = 8'h19;
  localparam logic [1:0]  ROOT_SRC_OSC_FLL = 2'h1;
  localparam int          BASE_CLKS        = 4;
  localparam logic [3:0]  BASE_CLK_ON      = 4'hf;
  localparam logic [3:0]  BASE_CLK_OFF     = 4'h0;
  localparam int          PERI_CLKS        = 8;

  typedef enum logic [1:0] {PM_NORMAL, PM_REDUCED, PM_DEEP, PM_HIB} rpm_pmode_type;

  typedef struct packed {
    logic        en;
    logic        rstEn;
    logic        clrOnMatch;
    logic        service;
    logic [31:0] match;
  } rpm_wdcfg_type;
endpackage
`default_nettype wire

// ==== rpm_reset_power.sv ====
// How it works
// - power-on reset holds everything until the supply has ramped.
// - supply droop detect resets the whole device.
// - ext_reset_n is active low; low pin holds device in reset.
// - an unserviced watchdog resets the device.
// - firmware can request a full device reset.
// - protection fault raises interrupt or reset, chosen by configuration.
// - leaving hibernate is done by a wakeup reset.
// - power-on, droop and pin resets assert asynchronously; internal requests at the next clock edge; all to a known state.
// - a cause register survives every reset except power-on.
// - mode entry waits for adequate supply; no supply ordering needed.
// - normal power runs core at 1.1 V, reduced at 0.9 V.
// - CPU sleep halts that CPU while system stays running.
// - CPU deep sleep halts the CPU and requests system deep sleep.
// - system deep sleep only when both CPUs sleep deeply; low-frequency only.
// - hibernate freezes state and pins until wakeup, which resets.
// - after reset root clock 0 from main oscillator via locked loop, 50/25 MHz.
// - at start only root, fast, peripheral and slow clocks run.
// - basic watchdog has one free-running 16-bit counter.
// - each multi-counter watchdog has two 16-bit and one 32-bit counter.
// - every 16-bit watchdog counter can reset; the 32-bit cannot.
// - every watchdog counter can interrupt on match.
// - basic watchdog runs from low-speed oscillator, wakes in all modes.
// - multi-counter watchdogs use low-frequency clock, not active in hibernate.
`timescale 1ns/1ps
`default_nettype none
module rpm_reset_power
  import rpm_pkg::*;
#(
  parameter int HOLD = RST_HOLD_CYC
)
(
  // clock and power-on reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // reset sources
  input  wire logic                    supplyDroopDetect,
  input  wire logic                    extResetN,
  input  wire logic                    softResetReq,
  input  wire logic                    protFault,
  input  wire logic                    protFaultRstEn,
  // reset cause
  input  wire logic [CAUSE_W-1:0]      causeClr,
  output logic [CAUSE_W-1:0]           resetCause_r,
  output logic                         sysRstN,
  output logic                         protFaultIrq_r,
  // power mode control
  input  wire logic                    supplyOk,
  input  wire logic                    reducedPowerSel,
  input  wire logic                    hibernateReq,
  input  wire logic                    wakeEvent,
  input  wire logic                    hibWakeEvent,
  input  wire logic [1:0]              cpuSleep,
  input  wire logic [1:0]              cpuDeepSleep,
  output rpm_pmode_type                pmode_r,
  output logic [1:0]                   cpuHalt_r,
  output logic [1:0]                   deepSleepReq_r,
  output logic                         lowFreqOnly_r,
  output logic                         ioFreeze_r,
  output logic [10:0]                  coreMv_r,
  // clock defaults
  input  wire logic                    periClkWr,
  input  wire logic [PERI_CLKS-1:0]    periClkData,
  output logic [1:0]                   rootClk0Src_r,
  output logic [7:0]                   rootClk0Mhz_r,
  output logic [BASE_CLKS-1:0]         baseClkEn_r,
  output logic [PERI_CLKS-1:0]         periClkEn_r,
  // watchdog clock ticks
  input  wire logic                    lowSpeedOscTick,
  input  wire logic                    watchXtalTick,
  input  wire logic                    lowFreqSel,
  // watchdog setup and results
  input  wire rpm_wdcfg_type           basicCfg,
  input  wire rpm_wdcfg_type [MC_TOTAL-1:0] multiCfg,
  output logic [WD_W-1:0]              basicCount_r,
  output logic                         basicIrq_r,
  output logic [MC_TOTAL-1:0]          multiIrq_r
);
  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic isRun(rpm_pmode_type m);
    isRun = (m == PM_NORMAL) || (m == PM_REDUCED);
  endfunction

  function automatic rpm_pmode_type runMode(logic reduced);
    runMode = reduced ? PM_REDUCED : PM_NORMAL;
  endfunction

  // ------------------------------------------------------------
  // internal reset requests
  // ------------------------------------------------------------
  logic                intRst_r;
  logic                rawRst_n;
  logic                basicRst;
  logic [MC_TOTAL-1:0] multiRst;
  logic                wdogRst;
  logic                faultRst;
  logic                hibWake;
  logic                intReq;

  assign wdogRst  = basicRst | (|multiRst);
  assign faultRst = protFault & protFaultRstEn;
  assign hibWake  = (pmode_r == PM_HIB) & (hibWakeEvent | basicIrq_r);
  assign intReq   = wdogRst | softResetReq | faultRst | hibWake;

  assign rawRst_n = rst_n & extResetN & ~supplyDroopDetect & ~intRst_r;

  // request held until the system reset has taken it
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      intRst_r <= 1'b0;
    else
      intRst_r <= intReq | (intRst_r & sysRstN);
  end

  rpm_rst_gen #(
    .HOLD     (HOLD)
  ) u_rst_gen (
    .sys_clk  (sys_clk),
    .rawRst_n (rawRst_n),
    .sysRst_n (sysRstN)
  );

  // ------------------------------------------------------------
  // retained reset cause
  // ------------------------------------------------------------
  logic [CAUSE_W-1:0] causeSet;
  logic [CAUSE_W-1:0] cause_nxt;

  assign causeSet[CB_POR]   = 1'b0;
  assign causeSet[CB_DROOP] = supplyDroopDetect;
  assign causeSet[CB_EXT]   = ~extResetN;
  assign causeSet[CB_WDOG]  = wdogRst;
  assign causeSet[CB_SOFT]  = softResetReq;
  assign causeSet[CB_FAULT] = faultRst;
  assign causeSet[CB_HIB]   = hibWake;

  assign cause_nxt = causeSet | (resetCause_r & ~causeClr);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      resetCause_r <= CAUSE_RST;
    else
      resetCause_r <= cause_nxt;
  end

  // ------------------------------------------------------------
  // power mode sequencer
  // ------------------------------------------------------------
  rpm_pmode_type pmode_nxt;
  logic          anyMultiIrq;
  logic          deepWake;

  assign anyMultiIrq = |multiIrq_r;
  assign deepWake    = wakeEvent | basicIrq_r | anyMultiIrq;

  always_comb
  begin
    pmode_nxt = pmode_r;
    case (pmode_r)
      PM_NORMAL, PM_REDUCED:
      begin
        if (supplyOk && hibernateReq)
          pmode_nxt = PM_HIB;
        else if (supplyOk && (&cpuDeepSleep))
          pmode_nxt = PM_DEEP;
        else if (supplyOk)
          pmode_nxt = runMode(reducedPowerSel);
      end
      PM_DEEP:
      begin
        if (deepWake && supplyOk)
          pmode_nxt = runMode(reducedPowerSel);
      end
      PM_HIB:
        pmode_nxt = PM_HIB;
      default:
        pmode_nxt = PM_NORMAL;
    endcase
  end

  // ------------------------------------------------------------
  // mode outputs
  // ------------------------------------------------------------
  logic [1:0]           cpuHalt_nxt;
  logic [1:0]           deepReq_nxt;
  logic [10:0]          coreMv_nxt;
  logic [7:0]           rootMhz_nxt;
  logic [BASE_CLKS-1:0] baseClk_nxt;
  logic [PERI_CLKS-1:0] periClk_nxt;
  logic                 nextRun;

  assign nextRun     = isRun(pmode_nxt);
  assign cpuHalt_nxt = nextRun ? (cpuSleep | cpuDeepSleep) : 2'h3;
  assign deepReq_nxt = nextRun ? cpuDeepSleep : 2'h0;
  assign coreMv_nxt  = (pmode_nxt == PM_NORMAL) ? VCORE_NORMAL_MV :
                       (pmode_nxt == PM_REDUCED) ? VCORE_REDUCED_MV : coreMv_r;
  assign rootMhz_nxt = (pmode_nxt == PM_REDUCED) ? ROOT_REDUCED_MHZ :
                       ROOT_NORMAL_MHZ;
  assign baseClk_nxt = nextRun ? BASE_CLK_ON : BASE_CLK_OFF;
  assign periClk_nxt = periClkWr ? periClkData : periClkEn_r;

  always_ff @(posedge sys_clk or negedge sysRstN)
  begin
    if (!sysRstN)
    begin
      pmode_r        <= PM_NORMAL;
      cpuHalt_r      <= 2'h0;
      deepSleepReq_r <= 2'h0;
      lowFreqOnly_r  <= 1'b0;
      ioFreeze_r     <= 1'b0;
      coreMv_r       <= VCORE_NORMAL_MV;
      rootClk0Src_r  <= ROOT_SRC_OSC_FLL;
      rootClk0Mhz_r  <= ROOT_NORMAL_MHZ;
      baseClkEn_r    <= BASE_CLK_ON;
      periClkEn_r    <= '0;
    end
    else
    begin
      pmode_r        <= pmode_nxt;
      cpuHalt_r      <= cpuHalt_nxt;
      deepSleepReq_r <= deepReq_nxt;
      lowFreqOnly_r  <= (pmode_nxt == PM_DEEP);
      ioFreeze_r     <= (pmode_nxt == PM_HIB);
      coreMv_r       <= coreMv_nxt;
      rootClk0Src_r  <= ROOT_SRC_OSC_FLL;
      rootClk0Mhz_r  <= rootMhz_nxt;
      baseClkEn_r    <= baseClk_nxt;
      periClkEn_r    <= periClk_nxt;
    end
  end

  // ------------------------------------------------------------
  // protection fault interrupt
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge sysRstN)
  begin
    if (!sysRstN)
      protFaultIrq_r <= 1'b0;
    else
      protFaultIrq_r <= protFault & ~protFaultRstEn;
  end

  // ------------------------------------------------------------
  // watchdogs
  // ------------------------------------------------------------
  logic basicTick;
  logic multiTick;

  assign basicTick = lowSpeedOscTick;
  assign multiTick = (lowFreqSel ? watchXtalTick : lowSpeedOscTick) &
                     (pmode_r != PM_HIB);

  rpm_wdog_ctr #(
    .W          (WD_W),
    .CAN_RST    (1'b1)
  ) u_basic (
    .sys_clk    (sys_clk),
    .rst_n      (sysRstN),
    .tick       (basicTick),
    .cfg        (basicCfg),
    .count_r    (basicCount_r),
    .matchIrq_r (basicIrq_r),
    .rstReq_r   (basicRst)
  );

  // two short and one long counter each
  for (genvar i = 0; i < MC_TOTAL; i++)
  begin : g_multi
    localparam bit IS_LONG = ((i % MC_CTRS) == MC_LONG);
    rpm_wdog_ctr #(
      .W          (IS_LONG ? MC_LW : MC_W),
      .CAN_RST    (!IS_LONG)
    ) u_ctr (
      .sys_clk    (sys_clk),
      .rst_n      (sysRstN),
      .tick       (multiTick),
      .cfg        (multiCfg[i]),
      .count_r    (),
      .matchIrq_r (multiIrq_r[i]),
      .rstReq_r   (multiRst[i])
    );
  end
endmodule
`default_nettype wire

// ==== rpm_reset_power_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module rpm_reset_power_asserts
  import rpm_pkg::*;
(
  // clock and reset
  input wire logic                 sys_clk,
  input wire logic                 rst_n,
  // reset sources
  input wire logic                 supplyDroopDetect,
  input wire logic                 extResetN,
  input wire logic                 softResetReq,
  input wire logic                 protFault,
  input wire logic                 protFaultRstEn,
  input wire logic [CAUSE_W-1:0]   causeClr,
  // reset results
  input wire logic [CAUSE_W-1:0]   resetCause_r,
  input wire logic                 sysRstN,
  input wire logic                 protFaultIrq_r,
  // power modes and clocks
  input wire logic                 supplyOk,
  input wire logic                 hibWakeEvent,
  input wire logic [1:0]           cpuDeepSleep,
  input wire rpm_pmode_type        pmode_r,
  input wire logic [10:0]          coreMv_r,
  input wire logic [1:0]           rootClk0Src_r,
  input wire logic [7:0]           rootClk0Mhz_r,
  input wire logic [BASE_CLKS-1:0] baseClkEn_r,
  input wire logic [PERI_CLKS-1:0] periClkEn_r
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  por_hold_a:
    assert property ($rose(rst_n) |-> !sysRstN && resetCause_r == CAUSE_RST)
    else $error("reset out or cause wrong after power-on");
  ext_pin_a:
    assert property (!extResetN |-> !sysRstN)
    else $error("reset out high while pin low");
  release_late_a:
    assert property ($rose(sysRstN) |-> extResetN && !supplyDroopDetect && $past(extResetN, 3))
    else $error("reset released too early");
  rst_state_a:
    assert property (!sysRstN |-> pmode_r == PM_NORMAL && coreMv_r == VCORE_NORMAL_MV
      && rootClk0Src_r == ROOT_SRC_OSC_FLL && baseClkEn_r == BASE_CLK_ON && periClkEn_r == '0)
    else $error("outputs not at default during reset");
  soft_rst_a:
    assert property (softResetReq && sysRstN |=> !sysRstN && resetCause_r[CB_SOFT])
    else $error("soft request gave no reset");
  fault_irq_a:
    assert property (protFault && !protFaultRstEn && sysRstN |=> protFaultIrq_r && sysRstN)
    else $error("fault gave no interrupt");
  fault_rst_a:
    assert property (protFault && protFaultRstEn && sysRstN |=> !sysRstN && resetCause_r[CB_FAULT])
    else $error("fault gave no reset");
  deep_entry_a:
    assert property (pmode_r == PM_DEEP && $past(pmode_r) != PM_DEEP
      |-> $past(cpuDeepSleep) == 2'h3 && $past(supplyOk))
    else $error("deep sleep entered without both cpus");
  mode_out_a:
    assert property (pmode_r inside {PM_NORMAL, PM_REDUCED} |->
      coreMv_r == (pmode_r == PM_REDUCED ? VCORE_REDUCED_MV : VCORE_NORMAL_MV)
      && rootClk0Mhz_r == (pmode_r == PM_REDUCED ? ROOT_REDUCED_MHZ : ROOT_NORMAL_MHZ))
    else $error("core voltage or root clock wrong for mode");
  hib_wake_a:
    assert property (pmode_r == PM_HIB && hibWakeEvent |=> !sysRstN && resetCause_r[CB_HIB])
    else $error("hibernate wake gave no reset");
  cause_sticky_a:
    assert property (($past(resetCause_r) & ~resetCause_r & ~$past(causeClr)) == '0)
    else $error("cause bit lost without clear");

  cover property (pmode_r == PM_DEEP);
  cover property (pmode_r == PM_HIB);
  cover property ($fell(sysRstN));
endmodule
bind rpm_reset_power rpm_reset_power_asserts rpm_reset_power_asserts_i (.*);
`default_nettype wire

// ==== rpm_reset_power_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module rpm_reset_power_test
  import rpm_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic supplyDroopDetect, extResetN, softResetReq, protFault, protFaultRstEn;
  logic sysRstN, protFaultIrq_r, supplyOk, reducedPowerSel, hibernateReq;
  logic wakeEvent, hibWakeEvent, lowFreqOnly_r, ioFreeze_r, periClkWr;
  logic lowSpeedOscTick, watchXtalTick, lowFreqSel, basicIrq_r;
  logic extReq, droopReq, lowReq;
  logic [1:0] cpuSleep, cpuDeepSleep, cpuHalt_r, deepSleepReq_r, rootClk0Src_r, deepReq;
  logic [CAUSE_W-1:0]   causeClr, resetCause_r, expC;
  logic [10:0]          coreMv_r;
  logic [7:0]           rootClk0Mhz_r;
  logic [BASE_CLKS-1:0] baseClkEn_r;
  logic [PERI_CLKS-1:0] periClkData, periClkEn_r;
  logic [WD_W-1:0]      basicCount_r;
  logic [MC_TOTAL-1:0]  multiIrq_r;
  logic [MC_TOTAL:0]    seen = '0;
  logic [39:0]          notes[$];
  logic [39:0]          note;
  rpm_pmode_type        pmode_r;
  rpm_wdcfg_type        basicCfg;
  rpm_wdcfg_type [MC_TOTAL-1:0] multiCfg;
  int srcBit[5] = '{CB_SOFT, CB_FAULT, CB_EXT, CB_DROOP, CB_HIB};
  int numErrors = 0;
  int nCompared = 0;
  int cycles = 0;
  int seed = 96175;
  int i;
  int k;

  rpm_reset_power #(.HOLD(RST_HOLD_CYC)) rpm_reset_power_i (.*);
  rpm_far_side rpm_far_side_i (.*);

  always #50 sys_clk = ~sys_clk;

  // ------
  // helpers
  // ------
  function automatic logic [31:0] obs(input logic [7:0] s);
    case (s)
      8'h0: obs = 32'(resetCause_r);
      8'h1: obs = 32'(sysRstN);
      8'h2: obs = 32'(pmode_r);
      8'h3: obs = 32'(coreMv_r);
      8'h4: obs = 32'(rootClk0Mhz_r);
      8'h5: obs = 32'(cpuHalt_r);
      8'h6: obs = 32'(deepSleepReq_r);
      8'h7: obs = 32'(lowFreqOnly_r);
      8'h8: obs = 32'(ioFreeze_r);
      8'h9: obs = 32'(periClkEn_r);
      8'ha: obs = 32'(protFaultIrq_r);
      8'hb: obs = 32'(baseClkEn_r);
      8'hc: obs = 32'(rootClk0Src_r);
      8'hd: obs = 32'(basicIrq_r);
      8'hf: obs = 32'(basicCount_r);
      default: obs = 32'(seen);
    endcase
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask

  task automatic chk(input logic [7:0] s, input logic [31:0] v);
    notes.push_back({s, v});
    step(1);
  endtask

  task automatic hit(input int s);
    case (s)
      0: softResetReq = 1'b1;
      1: {protFaultRstEn, protFault} = 2'h3;
      2: extReq = 1'b1;
      3: droopReq = 1'b1;
      default: hibWakeEvent = 1'b1;
    endcase
    step(1);
    {softResetReq, protFault, extReq, droopReq, hibWakeEvent} = '0;
    chk(8'h1, 32'h0);
    while (sysRstN !== 1'b1) step(1);
    expC[srcBit[s]] = 1'b1;
    chk(8'h0, 32'(expC));
  endtask

  task giveVerdict;
    $display("compared %0d, mismatched %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ------
  // watcher
  // ------
  always @(posedge sys_clk)
  begin
    seen <= seen | {multiIrq_r, basicIrq_r};
    if (notes.size() != 0)
    begin
      note = notes.pop_front();
      nCompared++;
      if (obs(note[39:32]) !== note[31:0])
      begin
        numErrors++;
        $display("wrong value at %0t: got %h, expected %h", $time, obs(note[39:32]), note[31:0]);
      end
    end
    cycles++;
    if (cycles == 3000)
    begin
      numErrors++;
      giveVerdict();
    end
  end

  // ------
  // stimulus
  // ------
  initial
  begin
    {softResetReq, protFault, protFaultRstEn, reducedPowerSel, hibernateReq} = '0;
    {wakeEvent, hibWakeEvent, periClkWr, lowFreqSel, extReq, droopReq, lowReq} = '0;
    {causeClr, cpuSleep, deepReq, periClkData} = '0;
    basicCfg = '0;
    multiCfg = '0;
    repeat (20) @(posedge sys_clk);
    #5;
    rst_n = 1'b1;
    expC = CAUSE_RST;
    chk(8'h1, 32'h0);
    chk(8'h9, 32'h0);
    chk(8'h0, 32'(CAUSE_RST));
    chk(8'hb, 32'(BASE_CLK_ON));
    chk(8'hc, 32'(ROOT_SRC_OSC_FLL));
    chk(8'hf, 32'h0);
    while (sysRstN !== 1'b1) step(1);
    reducedPowerSel = 1'b1;
    step(1);
    chk(8'h2, 32'(PM_REDUCED));
    chk(8'h3, 32'(VCORE_REDUCED_MV));
    chk(8'h4, 32'(ROOT_REDUCED_MHZ));
    reducedPowerSel = 1'b0;
    step(1);
    chk(8'h3, 32'(VCORE_NORMAL_MV));
    chk(8'h4, 32'(ROOT_NORMAL_MHZ));
    for (i = 0; i < 4; i++)
    begin
      cpuSleep = 2'($random(seed));
      step(1);
      chk(8'h5, 32'(cpuSleep));
    end
    cpuSleep = 2'h0;
    deepReq = 2'h1;
    step(2);
    chk(8'h6, 32'h1);
    chk(8'h5, 32'h1);
    chk(8'h2, 32'(PM_NORMAL));
    lowReq = 1'b1;
    deepReq = 2'h3;
    step(3);
    chk(8'h2, 32'(PM_NORMAL));
    lowReq = 1'b0;
    step(2);
    chk(8'h2, 32'(PM_DEEP));
    chk(8'h7, 32'h1);
    deepReq = 2'h0;
    step(2);
    wakeEvent = 1'b1;
    step(1);
    wakeEvent = 1'b0;
    chk(8'h2, 32'(PM_NORMAL));
    periClkData = 8'($random(seed));
    periClkWr = 1'b1;
    step(1);
    periClkWr = 1'b0;
    chk(8'h9, 32'(periClkData));
    protFault = 1'b1;
    step(1);
    protFault = 1'b0;
    chk(8'ha, 32'h1);
    chk(8'ha, 32'h0);
    for (k = 0; k < 4; k++) hit(k);
    basicCfg = '{1'b1, 1'b1, 1'b1, 1'b0, 32'h2};
    for (i = 0; i < 40; i++)
    begin
      basicCfg.service = i[0];
      chk(8'hd, 32'h0);
    end
    basicCfg.service = 1'b0;
    for (i = 0; i < 200 && sysRstN === 1'b1; i++) step(1);
    basicCfg.en = 1'b0;
    chk(8'h1, 32'h0);
    while (sysRstN !== 1'b1) step(1);
    expC[CB_WDOG] = 1'b1;
    chk(8'h0, 32'(expC));
    for (k = 0; k < MC_TOTAL; k++)
      multiCfg[k] = '{1'b1, 1'(k % 3 == 2), 1'b1, 1'b0, 32'h3};
    lowFreqSel = 1'($random(seed));
    step(120);
    chk(8'h1, 32'h1);
    chk(8'he, 32'h7f);
    multiCfg = '0;
    hibernateReq = 1'b1;
    step(1);
    hibernateReq = 1'b0;
    chk(8'h2, 32'(PM_HIB));
    chk(8'h8, 32'h1);
    wakeEvent = 1'b1;
    step(1);
    wakeEvent = 1'b0;
    chk(8'h2, 32'(PM_HIB));
    hit(4);
    causeClr = '1;
    step(1);
    causeClr = '0;
    chk(8'h0, 32'h0);
    giveVerdict();
  end
endmodule
`default_nettype wire

// ==== rpm_rst_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module rpm_rst_gen
  import rpm_pkg::*;
#(
  parameter int HOLD = RST_HOLD_CYC
)
(
  // clock and raw reset
  input  wire logic sys_clk,
  input  wire logic rawRst_n,
  // released reset
  output logic      sysRst_n
);
  logic [7:0] hold_r;
  logic [7:0] hold_nxt;

  assign hold_nxt = (hold_r == 8'(HOLD)) ? hold_r : hold_r + 8'h01;

  // asserts at once, releases after the hold count
  always_ff @(posedge sys_clk or negedge rawRst_n)
  begin
    if (!rawRst_n)
    begin
      hold_r   <= 8'h00;
      sysRst_n <= 1'b0;
    end
    else
    begin
      hold_r   <= hold_nxt;
      sysRst_n <= (hold_r == 8'(HOLD));
    end
  end
endmodule
`default_nettype wire

// ==== rpm_wdog_ctr.sv ====
`timescale 1ns/1ps
`default_nettype none
module rpm_wdog_ctr
  import rpm_pkg::*;
#(
  parameter int W       = WD_W,
  parameter bit CAN_RST = 1'b1
)
(
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  // count tick and setup
  input  wire logic          tick,
  input  wire rpm_wdcfg_type cfg,
  // results
  output logic [W-1:0]       count_r,
  output logic               matchIrq_r,
  output logic               rstReq_r
);
  logic hit;
  logic armed_r;
  logic [W-1:0] count_nxt;

  assign hit       = tick & cfg.en & (count_r == cfg.match[W-1:0]);
  assign count_nxt = (cfg.service | (hit & cfg.clrOnMatch)) ? '0 :
                     (tick & cfg.en) ? count_r + W'(1) : count_r;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_r    <= '0;
      matchIrq_r <= 1'b0;
      armed_r    <= 1'b0;
      rstReq_r   <= 1'b0;
    end
    else
    begin
      count_r    <= count_nxt;
      matchIrq_r <= hit;
      // match sets, service clears, set wins
      armed_r    <= hit | (armed_r & ~cfg.service);
      rstReq_r   <= rstReq_r | (CAN_RST & cfg.rstEn & hit & armed_r & ~cfg.service);
    end
  end
endmodule
`default_nettype wire
